// ===== ardc_pkg.sv
// Constants, field layouts and types for the converter result and reference block
// Functional notes
// - Left format: low result bits 7-6
// - Right format: high result bits 1-0
// - Right format: low register holds bits 7-0
// - Unused six result bits load as zero
// - Start bit set starts, cleared when done
// - Generator active only while enable set
// - Thirty-two levels from five-bit code
// - Enabled output follows code over thirty-two
// - Disabled, low-power set, code ones: positive
// - Disabled, low-power clear, code zero: negative
// - Positive source selectable; negative is ground
// - Output routed to comparator, converter, pin, sensing
// - Reset disables generator, pin and code
`default_nettype none
package ardc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ARDC_OFS_CTL_A = 12'h000;
  localparam logic [11:0] ARDC_OFS_CTL_B = 12'h004;
  localparam logic [11:0] ARDC_OFS_RES_HIGH = 12'h008;
  localparam logic [11:0] ARDC_OFS_RES_LOW = 12'h00C;
  localparam logic [11:0] ARDC_OFS_REF_CTL_A = 12'h010;
  localparam logic [11:0] ARDC_OFS_REF_LEVEL = 12'h014;
  localparam logic [11:0] ARDC_OFS_IRQ_STATUS = 12'h018;
  localparam logic [11:0] ARDC_OFS_IRQ_CLEAR = 12'h01C;
  localparam logic [11:0] ARDC_OFS_IRQ_ENABLE = 12'h020;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ARDC_BIT_ENABLE = 0;
  localparam int ARDC_BIT_GO = 1;
  localparam int ARDC_POS_CHANNEL = 2;
  localparam int ARDC_BIT_FORMAT = 7;
  localparam int ARDC_BIT_REF_EN = 7;
  localparam int ARDC_BIT_REF_LPS = 6;
  localparam int ARDC_BIT_REF_OE = 5;
  localparam int ARDC_POS_REF_PSS = 2;
  localparam int ARDC_BIT_IRQ_DONE = 0;

  // Writable bit masks; unimplemented bits read as zero
  localparam logic [7:0] ARDC_MASK_CTL_B = 8'hF7;
  localparam logic [7:0] ARDC_MASK_REF_CTL_A = 8'hEC;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ARDC_RST_CTL_B = 8'h00;
  localparam logic [7:0] ARDC_RST_RESULT = 8'h00;
  localparam logic [4:0] ARDC_RST_CHANNEL = 5'h00;
  localparam logic [4:0] ARDC_RST_LEVEL = 5'h00;
  localparam logic [4:0] ARDC_LEVEL_ALL_ONES = 5'h1F;
  localparam logic [4:0] ARDC_LEVEL_ALL_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ARDC_CLK_PERIOD_NS = 100;
  localparam int ARDC_BIT_TIME_NS = 200;
  localparam int ARDC_BIT_CYCLES =
    (ARDC_BIT_TIME_NS + ARDC_CLK_PERIOD_NS - 1) / ARDC_CLK_PERIOD_NS;
  localparam int ARDC_SYNC_STAGES = 2;

  localparam logic [1:0] ARDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ARDC_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic lowPower;
    logic pinEnable;
    logic [1:0] posSource;
  } ardc_ref_ctl_t;

  typedef enum logic [2:0] {
    ARDC_SAR_IDLE = 3'h1,
    ARDC_SAR_TRIAL = 3'h2,
    ARDC_SAR_DONE = 3'h4
  } ardc_sar_state_t;

endpackage : ardc_pkg
`default_nettype wire

// ===== ardc_sar.sv
// Successive-approximation sequencer producing the ten-bit conversion result
`timescale 1ns/10ps
`default_nettype none
module ardc_sar #(
  parameter int WIDTH = 10,
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic cmpAbove,
  output logic [WIDTH-1:0] trialCode,
  output logic [WIDTH-1:0] result,
  output logic done
);
  import ardc_pkg::*;

  ardc_sar_state_t state_reg;
  logic [$clog2(WIDTH)-1:0] bitIdx_reg;
  logic [$clog2(STEP_CYCLES+1)-1:0] wait_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ARDC_SAR_IDLE;
      bitIdx_reg <= '0;
      wait_reg <= '0;
      trialCode <= '0;
      result <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        ARDC_SAR_IDLE: begin
          if (start) begin
            bitIdx_reg <= ($clog2(WIDTH))'(WIDTH - 1);
            trialCode <= {1'b1, {(WIDTH-1){1'b0}}};
            wait_reg <= ($clog2(STEP_CYCLES+1))'(STEP_CYCLES);
            state_reg <= ARDC_SAR_TRIAL;
          end
        end
        ARDC_SAR_TRIAL: begin
          // Comparator path is slow and synchronised, so each trial is held
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end else begin
            trialCode[bitIdx_reg] <= cmpAbove;
            if (bitIdx_reg == '0) begin
              state_reg <= ARDC_SAR_DONE;
            end else begin
              trialCode[bitIdx_reg - 1'b1] <= 1'b1;
              bitIdx_reg <= bitIdx_reg - 1'b1;
              wait_reg <= ($clog2(STEP_CYCLES+1))'(STEP_CYCLES);
            end
          end
        end
        ARDC_SAR_DONE: begin
          result <= trialCode;
          done <= 1'b1;
          state_reg <= ARDC_SAR_IDLE;
        end
      endcase
    end
  end

endmodule : ardc_sar
`default_nettype wire

// ===== ardc_top.sv
// Converter result formatting, reference generator control and register slave
`timescale 1ns/10ps
`default_nettype none
module ardc_top #(
  parameter int RESULT_WIDTH = 10,
  parameter int LEVEL_WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog side of the converter
  input wire logic cmpAbove,
  output logic [RESULT_WIDTH-1:0] sarTrialCode,
  output logic converterEnable,
  output logic [4:0] inputChannelSelect,
  output logic [7:0] convConfig,
  // Reference ladder
  output logic [LEVEL_WIDTH-1:0] refLevelCode,
  output logic refLadderActive,
  output logic refPositiveConnect,
  output logic refNegativeConnect,
  output logic [1:0] ladderPositiveSource,
  output logic refOutputPinEnable,
  output logic refClampPositive,
  output logic refClampNegative,
  output logic irq
);
  import ardc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic goBusy_reg;
  logic [7:0] ctlB_reg;
  logic [7:0] resHigh_reg;
  logic [7:0] resLow_reg;
  ardc_ref_ctl_t refCtl_reg;
  logic [LEVEL_WIDTH-1:0] level_reg;
  logic [0:0] irqStatus_reg;
  logic [0:0] irqEnable_reg;

  // Write channel holding
  logic awHeld_reg;
  logic wHeld_reg;
  logic [11:0] awAddr_reg;
  logic [7:0] wByte_reg;
  logic wLane_reg;
  logic wrFire;
  logic wrHit;
  logic rdHit;
  logic [7:0] rdByte;

  // Converter handshake
  logic cmpSync1_reg;
  logic cmpSync2_reg;
  logic sarStart;
  logic sarDone;
  logic [RESULT_WIDTH-1:0] sarResult;
  logic goWrite;

  // ----------------------------------------------------------------
  // Write address / data capture, either order
  // ----------------------------------------------------------------
  assign wrFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wByte_reg <= '0;
      wLane_reg <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !wrFire;
      s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !wrFire;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wByte_reg <= s_axi_wdata[7:0];
        wLane_reg <= s_axi_wstrb[0];
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (awAddr_reg)
      ARDC_OFS_CTL_A, ARDC_OFS_CTL_B, ARDC_OFS_RES_HIGH, ARDC_OFS_RES_LOW,
      ARDC_OFS_REF_CTL_A, ARDC_OFS_REF_LEVEL, ARDC_OFS_IRQ_STATUS,
      ARDC_OFS_IRQ_CLEAR, ARDC_OFS_IRQ_ENABLE: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ARDC_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? ARDC_RESP_OKAY : ARDC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte lane 0 carries every field; other lanes are ignored
  function automatic logic wrTo(input logic [11:0] ofs);
    wrTo = wrFire && wLane_reg && (awAddr_reg == ofs);
  endfunction : wrTo

  // ----------------------------------------------------------------
  // Converter control
  // ----------------------------------------------------------------
  assign goWrite = wrTo(ARDC_OFS_CTL_A) && wByte_reg[ARDC_BIT_GO]
    && wByte_reg[ARDC_BIT_ENABLE];
  assign sarStart = goWrite && !goBusy_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converterEnable <= 1'b0;
      inputChannelSelect <= ARDC_RST_CHANNEL;
      ctlB_reg <= ARDC_RST_CTL_B;
    end else begin
      if (wrTo(ARDC_OFS_CTL_A)) begin
        converterEnable <= wByte_reg[ARDC_BIT_ENABLE];
        inputChannelSelect <= wByte_reg[ARDC_POS_CHANNEL +: 5];
      end
      if (wrTo(ARDC_OFS_CTL_B)) begin
        ctlB_reg <= wByte_reg & ARDC_MASK_CTL_B;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      goBusy_reg <= 1'b0;
    end else if (sarStart) begin
      goBusy_reg <= 1'b1;
    end else if (sarDone) begin
      goBusy_reg <= 1'b0;
    end
  end

  // Acquisition timing is software's duty; a start is taken as written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmpSync1_reg <= 1'b0;
      cmpSync2_reg <= 1'b0;
    end else begin
      cmpSync1_reg <= cmpAbove;
      cmpSync2_reg <= cmpSync1_reg;
    end
  end

  ardc_sar #(
    .WIDTH(RESULT_WIDTH),
    .STEP_CYCLES(ARDC_BIT_CYCLES + ARDC_SYNC_STAGES)
  ) u_sar (
    .clk(clk),
    .rst(rst),
    .start(sarStart),
    .cmpAbove(cmpSync2_reg),
    .trialCode(sarTrialCode),
    .result(sarResult),
    .done(sarDone)
  );

  // ----------------------------------------------------------------
  // Result registers: hardware load wins over a software write
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resHigh_reg <= ARDC_RST_RESULT;
      resLow_reg <= ARDC_RST_RESULT;
    end else if (sarDone) begin
      // Format sampled here, at the finish
      if (ctlB_reg[ARDC_BIT_FORMAT]) begin
        resHigh_reg <= {6'h00, sarResult[9:8]};
        resLow_reg <= sarResult[7:0];
      end else begin
        resHigh_reg <= sarResult[9:2];
        resLow_reg <= {sarResult[1:0], 6'h00};
      end
    end else begin
      if (wrTo(ARDC_OFS_RES_HIGH)) begin
        resHigh_reg <= wByte_reg;
      end
      if (wrTo(ARDC_OFS_RES_LOW)) begin
        resLow_reg <= wByte_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference generator control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refCtl_reg <= '0;
      level_reg <= ARDC_RST_LEVEL;
    end else begin
      if (wrTo(ARDC_OFS_REF_CTL_A)) begin
        refCtl_reg.enable <= wByte_reg[ARDC_BIT_REF_EN];
        refCtl_reg.lowPower <= wByte_reg[ARDC_BIT_REF_LPS];
        refCtl_reg.pinEnable <= wByte_reg[ARDC_BIT_REF_OE];
        refCtl_reg.posSource <= wByte_reg[ARDC_POS_REF_PSS +: 2];
      end
      if (wrTo(ARDC_OFS_REF_LEVEL)) begin
        level_reg <= wByte_reg[LEVEL_WIDTH-1:0];
      end
    end
  end

  // Outputs mirror the control state one cycle later, from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refLevelCode <= ARDC_RST_LEVEL;
      refLadderActive <= 1'b0;
      refPositiveConnect <= 1'b0;
      refNegativeConnect <= 1'b0;
      ladderPositiveSource <= 2'h0;
      refOutputPinEnable <= 1'b0;
      refClampPositive <= 1'b0;
      refClampNegative <= 1'b0;
      convConfig <= 8'h00;
    end else begin
      // One code feeds comparator, converter channel, pin and sensing
      refLevelCode <= level_reg;
      refLadderActive <= refCtl_reg.enable;
      // Disabled ladder keeps only one end connected to save current
      refPositiveConnect <= refCtl_reg.enable || refCtl_reg.lowPower;
      refNegativeConnect <= refCtl_reg.enable || !refCtl_reg.lowPower;
      ladderPositiveSource <= refCtl_reg.posSource;
      refOutputPinEnable <= refCtl_reg.pinEnable;
      refClampPositive <= !refCtl_reg.enable && refCtl_reg.lowPower
        && (level_reg == ARDC_LEVEL_ALL_ONES);
      refClampNegative <= !refCtl_reg.enable && !refCtl_reg.lowPower
        && (level_reg == ARDC_LEVEL_ALL_ZERO);
      convConfig <= ctlB_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt: sticky done flag, set beats clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus_reg <= '0;
      irqEnable_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (sarDone) begin
        irqStatus_reg[ARDC_BIT_IRQ_DONE] <= 1'b1;
      end else if (wrTo(ARDC_OFS_IRQ_CLEAR) && wByte_reg[ARDC_BIT_IRQ_DONE]) begin
        irqStatus_reg[ARDC_BIT_IRQ_DONE] <= 1'b0;
      end
      if (wrTo(ARDC_OFS_IRQ_ENABLE)) begin
        irqEnable_reg <= wByte_reg[0:0];
      end
      irq <= |(irqStatus_reg & irqEnable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rdHit = 1'b1;
    rdByte = 8'h00;
    unique case (s_axi_araddr)
      ARDC_OFS_CTL_A: rdByte = {1'b0, inputChannelSelect, goBusy_reg, converterEnable};
      ARDC_OFS_CTL_B: rdByte = ctlB_reg;
      ARDC_OFS_RES_HIGH: rdByte = resHigh_reg;
      ARDC_OFS_RES_LOW: rdByte = resLow_reg;
      ARDC_OFS_REF_CTL_A: rdByte = {refCtl_reg.enable, refCtl_reg.lowPower,
        refCtl_reg.pinEnable, 1'b0, refCtl_reg.posSource, 2'h0};
      ARDC_OFS_REF_LEVEL: rdByte = {3'h0, level_reg};
      ARDC_OFS_IRQ_STATUS: rdByte = {7'h00, irqStatus_reg};
      ARDC_OFS_IRQ_CLEAR: rdByte = 8'h00;
      ARDC_OFS_IRQ_ENABLE: rdByte = {7'h00, irqEnable_reg};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ARDC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdHit ? ARDC_RESP_OKAY : ARDC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : ardc_top
`default_nettype wire

// ===== ardc_top_monitor.sv
// Checker for the reference generator outputs of the converter block
`timescale 1ns/10ps
`default_nettype none
module ardc_top_monitor
  import ardc_pkg::*;
#(
  parameter int LEVEL_WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic [LEVEL_WIDTH-1:0] refLevelCode,
  input wire logic refLadderActive,
  input wire logic refPositiveConnect,
  input wire logic refNegativeConnect,
  input wire logic [1:0] ladderPositiveSource,
  input wire logic refOutputPinEnable,
  input wire logic refClampPositive,
  input wire logic refClampNegative
);
  import ardc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Output relations
  // ----------------------------------------------------------------
  property p_clamp_pos;
    refClampPositive == (!refLadderActive && refPositiveConnect && refLevelCode == 5'h1F);
  endproperty
  a_clamp_pos: assert property (p_clamp_pos)
    else $error("positive clamp disagrees with its conditions");
  property p_clamp_neg;
    refClampNegative == (!refLadderActive && refNegativeConnect && refLevelCode == 5'h00);
  endproperty
  a_clamp_neg: assert property (p_clamp_neg)
    else $error("negative clamp disagrees with its conditions");
  property p_connect;
    refLadderActive |-> refPositiveConnect && refNegativeConnect;
  endproperty
  a_connect: assert property (p_connect)
    else $error("active ladder lacks a source");
  // Registered outputs still hold reset values at the first edge after release
  property p_one_side;
    !refLadderActive && !$past(rst) |-> refPositiveConnect ^ refNegativeConnect;
  endproperty
  a_one_side: assert property (p_one_side)
    else $error("idle ladder must keep exactly one source");
  property p_reset;
    disable iff (1'b0) rst |-> !refLadderActive && !refOutputPinEnable && refLevelCode == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("generator not cleared in reset");

  // ----------------------------------------------------------------
  // Outputs move only after a register write
  // ----------------------------------------------------------------
  property p_active_cause;
    $changed(refLadderActive) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_active_cause: assert property (p_active_cause)
    else $error("generator enable moved without a write");
  property p_level_cause;
    $changed(refLevelCode) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_level_cause: assert property (p_level_cause)
    else $error("level code moved without a write");
  property p_pin_cause;
    $changed(refOutputPinEnable) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin enable moved without a write");
  property p_src_cause;
    $changed(ladderPositiveSource) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_src_cause: assert property (p_src_cause)
    else $error("positive source moved without a write");
endmodule : ardc_top_monitor

bind ardc_top ardc_top_monitor #(.LEVEL_WIDTH(LEVEL_WIDTH)) i_monitor (
  .clk(clk),
  .rst(rst),
  .s_axi_bvalid(s_axi_bvalid),
  .refLevelCode(refLevelCode),
  .refLadderActive(refLadderActive),
  .refPositiveConnect(refPositiveConnect),
  .refNegativeConnect(refNegativeConnect),
  .ladderPositiveSource(ladderPositiveSource),
  .refOutputPinEnable(refOutputPinEnable),
  .refClampPositive(refClampPositive),
  .refClampNegative(refClampNegative)
);
`default_nettype wire

// ===== ardc_top_test.sv
// Self-checking bench for the converter result and reference block
`timescale 1ns/10ps
`default_nettype none
module ardc_top_test;
  import ardc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Ready for responses at all times; a compliant master may do so
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, cmpAbove = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ladderPositiveSource, pss;
  logic [31:0] s_axi_rdata;
  logic [9:0] sarTrialCode, target = 10'h000;
  logic [4:0] inputChannelSelect, refLevelCode, chan, code;
  logic [7:0] convConfig, hi, lo, ctl;
  logic converterEnable, refLadderActive, refPositiveConnect, refNegativeConnect;
  logic refOutputPinEnable, refClampPositive, refClampNegative, irq, fmt, en, lps, oe;
  logic [33:0] expQ[$];
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h197e;

  ardc_top i_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cmpAbove(cmpAbove), .sarTrialCode(sarTrialCode), .converterEnable(converterEnable),
    .inputChannelSelect(inputChannelSelect), .convConfig(convConfig),
    .refLevelCode(refLevelCode), .refLadderActive(refLadderActive),
    .refPositiveConnect(refPositiveConnect), .refNegativeConnect(refNegativeConnect),
    .ladderPositiveSource(ladderPositiveSource), .refOutputPinEnable(refOutputPinEnable),
    .refClampPositive(refClampPositive), .refClampNegative(refClampNegative), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock, ideal comparator, response watcher
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  always @(posedge clk) cmpAbove <= (target >= sarTrialCode);

  task check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, expQ.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
  end

  task final_report;
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
    expQ.push_back({resp, 32'h0});
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr

  task rd(input logic [11:0] a, input logic [33:0] exp);
    expQ.push_back(exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask : rd

  task irq_is(input logic v);
    repeat (3) @(posedge clk);
    check({33'h0, irq}, {33'h0, v});
  endtask : irq_is

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    // A real edge on rst so the asynchronous reset takes hold before the first clock
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ARDC_OFS_CTL_A, 34'h0);
    rd(ARDC_OFS_RES_HIGH, 34'h0);
    rd(ARDC_OFS_REF_CTL_A, 34'h0);
    rd(ARDC_OFS_REF_LEVEL, 34'h0);
    rd(12'h040, {ARDC_RESP_SLVERR, 32'h0});
    wr(12'h040, 8'hFF, ARDC_RESP_SLVERR);
    wr(ARDC_OFS_CTL_B, 8'hFF, ARDC_RESP_OKAY);
    rd(ARDC_OFS_CTL_B, {26'h0, ARDC_MASK_CTL_B});
    wr(ARDC_OFS_REF_CTL_A, 8'hFF, ARDC_RESP_OKAY);
    rd(ARDC_OFS_REF_CTL_A, {26'h0, ARDC_MASK_REF_CTL_A});
    wr(ARDC_OFS_REF_LEVEL, 8'hFF, ARDC_RESP_OKAY);
    rd(ARDC_OFS_REF_LEVEL, {26'h0, 8'h1F});
    wr(ARDC_OFS_IRQ_ENABLE, 8'h01, ARDC_RESP_OKAY);
    $display("register test done");
    // Format is flipped mid-conversion; the finish-time value must win
    for (int i = 0; i < 6; i++) begin
      target <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed));
      fmt = i[0];
      chan = 5'($random(seed));
      wr(ARDC_OFS_CTL_B, {~fmt, 7'h0}, ARDC_RESP_OKAY);
      wr(ARDC_OFS_RES_HIGH, 8'hFF, ARDC_RESP_OKAY);
      wr(ARDC_OFS_RES_LOW, 8'hFF, ARDC_RESP_OKAY);
      rd(ARDC_OFS_RES_LOW, {26'h0, 8'hFF});
      wr(ARDC_OFS_CTL_A, {1'b0, chan, 2'b01}, ARDC_RESP_OKAY);
      repeat (50) @(posedge clk);
      wr(ARDC_OFS_CTL_A, {1'b0, chan, 2'b11}, ARDC_RESP_OKAY);
      rd(ARDC_OFS_CTL_A, {27'h0, chan, 2'b11});
      check({28'h0, inputChannelSelect, converterEnable}, {28'h0, chan, 1'b1});
      wr(ARDC_OFS_CTL_B, {fmt, 7'h0}, ARDC_RESP_OKAY);
      for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clk);
      check({33'h0, irq}, 34'h1);
      check({16'h0, convConfig, sarTrialCode}, {16'h0, fmt, 7'h0, target});
      rd(ARDC_OFS_CTL_A, {27'h0, chan, 2'b01});
      hi = fmt ? {6'h0, target[9:8]} : target[9:2];
      lo = fmt ? target[7:0] : {target[1:0], 6'h0};
      rd(ARDC_OFS_RES_HIGH, {26'h0, hi});
      rd(ARDC_OFS_RES_LOW, {26'h0, lo});
      rd(ARDC_OFS_IRQ_STATUS, 34'h1);
      wr(ARDC_OFS_IRQ_ENABLE, 8'h00, ARDC_RESP_OKAY);
      irq_is(1'b0);
      wr(ARDC_OFS_IRQ_ENABLE, 8'h01, ARDC_RESP_OKAY);
      irq_is(1'b1);
      wr(ARDC_OFS_IRQ_CLEAR, 8'h01, ARDC_RESP_OKAY);
      irq_is(1'b0);
      rd(ARDC_OFS_IRQ_STATUS, 34'h0);
    end
    $display("conversion test done");
    for (int i = 0; i < 8; i++) begin
      en = i[0];
      lps = i[1];
      code = i[2] ? (lps ? 5'h1F : 5'h00) : 5'($random(seed));
      oe = 1'($random(seed));
      pss = 2'(i % 3);
      ctl = {en, lps, oe, 1'b0, pss, 2'b00};
      wr(ARDC_OFS_REF_CTL_A, ctl, ARDC_RESP_OKAY);
      wr(ARDC_OFS_REF_LEVEL, {3'h0, code}, ARDC_RESP_OKAY);
      repeat (2) @(posedge clk);
      check({28'h0, refLadderActive, refPositiveConnect, refNegativeConnect, refOutputPinEnable,
        ladderPositiveSource}, {28'h0, en, en | lps, en | !lps, oe, pss});
      check({32'h0, refClampPositive, refClampNegative},
        {32'h0, !en && lps && &code, !en && !lps && ~|code});
      check({29'h0, refLevelCode}, {29'h0, code});
      rd(ARDC_OFS_REF_CTL_A, {26'h0, ctl});
      rd(ARDC_OFS_REF_LEVEL, {29'h0, code});
    end
    $display("reference test done");
    wr(ARDC_OFS_REF_CTL_A, 8'hA0, ARDC_RESP_OKAY);
    wr(ARDC_OFS_REF_LEVEL, 8'h15, ARDC_RESP_OKAY);
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, refLadderActive, refOutputPinEnable, |refLevelCode}, 34'h0);
    rst <= 1'b0;
    @(posedge clk);
    rd(ARDC_OFS_REF_LEVEL, 34'h0);
    rd(ARDC_OFS_REF_CTL_A, 34'h0);
    $display("reset test done");
    final_report();
  end
endmodule : ardc_top_test
`default_nettype wire
